// file: pkg/lsd_cfg.svh
`ifndef LSD_CFG_SVH
`define LSD_CFG_SVH

// Register byte offsets on the bus
`define LSD_BANK_SEL_OFS   12'h004
`define LSD_PTR_OFS        12'h008
`define LSD_IND_DATA_OFS   12'h00C
`define LSD_STATUS_OFS     12'h010
// Direct data memory window: byte address = base + 4 * location
`define LSD_DIRECT_BASE    12'h100
`define LSD_DIRECT_LAST    12'h4FF

// Bank selection codes
`define LSD_BANK_GENERAL   8'h00
`define LSD_BANK_DISPLAY   8'h01

// Display memory location range
`define LSD_DISP_FIRST     8'h40
`define LSD_DISP_LAST_SML  8'h53
`define LSD_DISP_LAST_LRG  8'h54

// Reset values
`define LSD_BANK_RST       8'h00
`define LSD_PTR_RST        8'h00
`define LSD_MEM_RST        8'h00

// Optional segment pin span and shared pin index
`define LSD_OPT_SEG_LO     9
`define LSD_OPT_SEG_HI     18
`define LSD_SHARED_SEG     19

// Status register field positions
`define LSD_ST_COM_LSB     0
`define LSD_ST_POL_BIT     2
`define LSD_ST_RUN_BIT     3

`endif

// file: pkg/lsd_pkg.sv
package lsd_pkg;

	// Drive level of one panel pin under 1/2 bias
	typedef enum logic [1:0] {
		LSD_LVL_GND,
		LSD_LVL_MID,
		LSD_LVL_TOP
	} lsd_level_type;

	// All common and segment drive levels
	typedef struct packed {
		lsd_level_type [2:0]  com;
		lsd_level_type [20:0] seg;
	} lsd_drive_type;

	// One bus request as seen by the slave
	typedef struct packed {
		logic [11:0] addr;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
	} lsd_req_type;

endpackage

// file: rtl/lsd_lcd_segment_driver.sv
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
`include "lsd_cfg.svh"
// Overview of operation
// - Bank select 01H routes indirect access of 40H..last to display memory.
// - Bank select 00H routes that range to general memory instead.
// - Display memory is reached only through indirect pointer one.
// - Driver scans display memory continuously without processor help.
// - Bit one lights its segment, bit zero leaves it dark.
// - Layout is 20x2 or 19x3 small, 21x3 large, fixed at build.
// - Large variant at 1/3 duty uses 1/2 bias levels.
// - Driver clock is system clock over a build-time power of two.
// - Divider exponent is three, four, five or six.
// - Shared pin is common 2 on the small variant at 1/3 duty, segment 19 otherwise.
// - Segments 9 to 18 each build-time choosable as I/O or LCD.
// - Build option keeps driver running or stops it in power down.
// - In power down the driver is off or on per that option.
module lsd_lcd_segment_driver #(
	parameter bit        LARGE      = 1'b0,
	parameter bit        DUTY3      = 1'b0,
	parameter int        DIV_EXP    = 5,
	parameter bit [9:0]  OPT_SEG_LCD = 10'h3FF,
	parameter bit        PD_KEEP_ON = 1'b0
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic [11:0]            avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	output logic [31:0]                 avs_readdata,
	output logic                        avs_waitrequest,
	input  wire logic                   power_down,
	input  wire logic [9:0]             gpio_out,
	output lsd_pkg::lsd_drive_type      lcd_drive_ff,
	output lsd_pkg::lsd_level_type      shared_common_segment_pin
);

	// Build-time organisation
	localparam int NCOM = (LARGE || DUTY3) ? 3 : 2;
	localparam int NSEG = LARGE ? 21 : (DUTY3 ? 19 : 20);
	localparam int NMEM = LARGE ? 21 : 20;
	localparam logic [7:0] DISP_LAST =
		LARGE ? `LSD_DISP_LAST_LRG : `LSD_DISP_LAST_SML;
	localparam logic [1:0] COM_LAST = 2'(NCOM - 1);

	// Display range decode, used by both access paths
	function automatic logic in_disp(input logic [7:0] loc);
		in_disp = (loc >= `LSD_DISP_FIRST) && (loc <= DISP_LAST);
	endfunction

	// Location to array index
	function automatic logic [4:0] mem_idx(input logic [7:0] loc);
		logic [7:0] d;
		d = loc - `LSD_DISP_FIRST;
		mem_idx = d[4:0];
	endfunction

	// Full swing rail: the high half drives the top level
	function automatic lsd_pkg::lsd_level_type rail(input logic hi);
		rail = hi ? lsd_pkg::LSD_LVL_TOP : lsd_pkg::LSD_LVL_GND;
	endfunction

	// Segment pins built as plain port outputs, fixed at build
	function automatic bit seg_is_io(input int s);
		seg_is_io = 1'b0;
		if (s >= `LSD_OPT_SEG_LO && s <= `LSD_OPT_SEG_HI) begin
			seg_is_io = !OPT_SEG_LCD[s - `LSD_OPT_SEG_LO];
		end
	endfunction

	// Software visible registers and memories
	logic [7:0]  bank_ff;
	logic [7:0]  ptr_ff;
	logic [7:0]  disp_mem_ff [NMEM];
	logic [7:0]  gen_mem_ff  [NMEM];

	// Bus handshake and captured read data
	logic        ack_ff;
	logic [31:0] rdata_ff;

	// Driver clock divider and scan position
	logic [DIV_EXP-1:0] div_cnt_ff;
	logic        pol_ff;
	logic [1:0]  com_idx_ff;
	lsd_pkg::lsd_level_type shared_ff;

	// Decoded request and access steering
	lsd_pkg::lsd_req_type req;
	logic        take_wr;
	logic        ind_disp;
	logic        ind_gen;
	logic [11:0] dir_ofs;
	logic [7:0]  dir_loc;
	logic        dir_gen;
	logic [7:0]  ind_rd;
	logic [7:0]  status;
	logic [31:0] nxt_rdata;

	// Scan control and per-pin drive levels
	logic        run;
	logic        tick;
	lsd_pkg::lsd_level_type com_lvl [3];
	lsd_pkg::lsd_level_type seg_lvl [21];
	lsd_pkg::lsd_drive_type nxt_drive;

	// Request bundle
	assign req = '{addr: avs_address, rd: avs_read,
		wr: avs_write, wdata: avs_writedata[7:0]};

	// One wait cycle per request, answered on the second edge
	assign avs_waitrequest = (req.rd || req.wr) && !ack_ff;

	// Read data straight from its register
	assign avs_readdata    = rdata_ff;

	// A write lands at the edge where the master sees wait low
	assign take_wr         = req.wr && ack_ff;

	// Indirect path steered by the bank select
	assign ind_disp = (bank_ff == `LSD_BANK_DISPLAY) && in_disp(ptr_ff);
	assign ind_gen  = (bank_ff == `LSD_BANK_GENERAL) && in_disp(ptr_ff);

	// Direct window only ever reaches general memory
	assign dir_ofs = req.addr - `LSD_DIRECT_BASE;
	assign dir_loc = dir_ofs[9:2]; // Word offset gives the location
	assign dir_gen = (req.addr >= `LSD_DIRECT_BASE) &&
		(req.addr <= `LSD_DIRECT_LAST) && in_disp(dir_loc);

	// Handshake state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (req.rd || req.wr) && !ack_ff;
		end
	end

	// Indirect data read mux
	always_comb begin
		ind_rd = 8'h00;
		if (ind_disp) begin
			ind_rd = disp_mem_ff[mem_idx(ptr_ff)];
		end else if (ind_gen) begin
			ind_rd = gen_mem_ff[mem_idx(ptr_ff)];
		end
	end

	// Status byte: scan position and running flag
	always_comb begin
		status = 8'h00;
		status[`LSD_ST_COM_LSB +: 2] = com_idx_ff;
		status[`LSD_ST_POL_BIT]      = pol_ff;
		status[`LSD_ST_RUN_BIT]      = run;
	end

	// Read data decode, unmapped reads return zero
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (req.addr == `LSD_BANK_SEL_OFS) begin
			nxt_rdata[7:0] = bank_ff;
		end else if (req.addr == `LSD_PTR_OFS) begin
			nxt_rdata[7:0] = ptr_ff;
		end else if (req.addr == `LSD_IND_DATA_OFS) begin
			nxt_rdata[7:0] = ind_rd;
		end else if (req.addr == `LSD_STATUS_OFS) begin
			nxt_rdata[7:0] = status;
		end else if (dir_gen) begin
			nxt_rdata[7:0] = gen_mem_ff[mem_idx(dir_loc)];
		end
	end

	// Read data captured at the first edge of a read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 32'h0000_0000;
		end else if (req.rd && !ack_ff) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// Bank select register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_ff <= `LSD_BANK_RST;
		end else if (take_wr && req.addr == `LSD_BANK_SEL_OFS) begin
			bank_ff <= req.wdata;
		end
	end

	// Indirect pointer register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_ff <= `LSD_PTR_RST;
		end else if (take_wr && req.addr == `LSD_PTR_OFS) begin
			ptr_ff <= req.wdata;
		end
	end

	// Display memory, written only through the pointer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NMEM; i++) begin
				disp_mem_ff[i] <= `LSD_MEM_RST;
			end
		end else if (take_wr && req.addr == `LSD_IND_DATA_OFS &&
				ind_disp) begin
			disp_mem_ff[mem_idx(ptr_ff)] <= req.wdata;
		end
	end

	// General memory over the same range, both access paths
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NMEM; i++) begin
				gen_mem_ff[i] <= `LSD_MEM_RST;
			end
		end else if (take_wr) begin
			if (req.addr == `LSD_IND_DATA_OFS && ind_gen) begin
				gen_mem_ff[mem_idx(ptr_ff)] <= req.wdata;
			end else if (dir_gen) begin
				gen_mem_ff[mem_idx(dir_loc)] <= req.wdata;
			end
		end
	end

	// Driver runs unless power down stops it
	assign run = !power_down || PD_KEEP_ON;

	// Driver clock tick every 2**DIV_EXP system clocks
	assign tick = run && (&div_cnt_ff);

	// Divider, held at zero while stopped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_ff <= '0;
		end else if (!run) begin
			div_cnt_ff <= '0;
		end else begin
			div_cnt_ff <= div_cnt_ff + 1'b1;
		end
	end

	// Polarity half, flipped at every driver clock tick
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pol_ff <= 1'b0;
		end else if (!run) begin
			pol_ff <= 1'b0;
		end else if (tick) begin
			pol_ff <= !pol_ff;
		end
	end

	// Common index, advanced after both halves of a common
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			com_idx_ff <= 2'h0;
		end else if (!run) begin
			com_idx_ff <= 2'h0;
		end else if (tick && pol_ff) begin
			com_idx_ff <= (com_idx_ff == COM_LAST) ?
				2'h0 : com_idx_ff + 2'h1;
		end
	end

	// One level decoder per common pin
	for (genvar c = 0; c < 3; c++) begin : g_com
		if (c >= NCOM) begin : g_unused
			// Commons beyond the built layout stay at ground
			assign com_lvl[c] = lsd_pkg::LSD_LVL_GND;
		end else begin : g_used
			// Selected common swings full, others sit at mid bias
			always_comb begin
				if (!run) begin
					com_lvl[c] = lsd_pkg::LSD_LVL_GND;
				end else if (c == int'(com_idx_ff)) begin
					com_lvl[c] = rail(pol_ff);
				end else begin
					com_lvl[c] = lsd_pkg::LSD_LVL_MID;
				end
			end
		end
	end

	// One level decoder per segment pin
	for (genvar s = 0; s < 21; s++) begin : g_seg
		if (s >= NSEG) begin : g_spare
			// Pins beyond the built layout stay at ground
			assign seg_lvl[s] = lsd_pkg::LSD_LVL_GND;
		end else if (seg_is_io(s)) begin : g_io
			// Port value passes through, also in power down
			assign seg_lvl[s] =
				rail(gpio_out[s - `LSD_OPT_SEG_LO]);
		end else begin : g_lcd
			// Lit segment opposes the selected common, dark follows it
			always_comb begin
				if (!run) begin
					seg_lvl[s] = lsd_pkg::LSD_LVL_GND;
				end else if (disp_mem_ff[s][com_idx_ff]) begin
					seg_lvl[s] = rail(!pol_ff);
				end else begin
					seg_lvl[s] = rail(pol_ff);
				end
			end
		end
	end

	// Gather the per-pin levels into the next drive word
	always_comb begin
		nxt_drive = '0;
		for (int c = 0; c < 3; c++) begin
			nxt_drive.com[c] = com_lvl[c];
		end
		for (int s = 0; s < 21; s++) begin
			nxt_drive.seg[s] = seg_lvl[s];
		end
	end

	// Registered panel drive
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lcd_drive_ff <= '0;
		end else begin
			lcd_drive_ff <= nxt_drive;
		end
	end

	// Shared pin function on the small variant
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shared_ff <= lsd_pkg::LSD_LVL_GND;
		end else if (!LARGE && DUTY3) begin
			shared_ff <= nxt_drive.com[2];
		end else begin
			shared_ff <= nxt_drive.seg[`LSD_SHARED_SEG];
		end
	end

	// Shared pin output
	assign shared_common_segment_pin = shared_ff;

endmodule

// file: test/lsd_lcd_segment_driver_assertions.sv
`timescale 1ns/1ns
`include "lsd_cfg.svh"
module lsd_seg_checker #(
	parameter bit       LARGE       = 1'b0,
	parameter bit       DUTY3       = 1'b0,
	parameter int       DIV_EXP     = 5,
	parameter bit [9:0] OPT_SEG_LCD = 10'h3FF,
	parameter bit       PD_KEEP_ON  = 1'b0
) (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic [11:0]       avs_address,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic [31:0]       avs_writedata,
	input wire logic [31:0]       avs_readdata,
	input wire logic              avs_waitrequest,
	input wire logic              power_down,
	input wire logic [9:0]        gpio_out,
	input lsd_pkg::lsd_drive_type lcd_drive_ff,
	input lsd_pkg::lsd_level_type shared_common_segment_pin
);
	localparam int PER = 2 ** DIV_EXP;
	logic [7:0] held_ff;
	logic       segs_dark;
	// LCD-built segments at ground; port-built ones keep their level
	always_comb begin
		segs_dark = 1'b1;
		for (int s = 0; s < 21; s++) begin
			if (!(s >= `LSD_OPT_SEG_LO && s <= `LSD_OPT_SEG_HI &&
					!OPT_SEG_LCD[s - `LSD_OPT_SEG_LO]) &&
					lcd_drive_ff.seg[s] != lsd_pkg::LSD_LVL_GND) begin
				segs_dark = 1'b0;
			end
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Cycles since the common levels last moved
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			held_ff <= 8'h00;
		else if (power_down || $changed(lcd_drive_ff.com))
			held_ff <= 8'h00;
		else
			held_ff <= held_ff + 8'h01;
	end
	wait_once_a: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait too long");
	rd_hold_a: assert property (
		!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data moved");
	pd_dark_a: assert property ((!PD_KEEP_ON && power_down)[*3] |->
		lcd_drive_ff.com == '0 && segs_dark &&
		shared_common_segment_pin == '0)
		else $error("drive on in power down");
	seg_rail_a: assert property (
		lcd_drive_ff.seg[0] != lsd_pkg::LSD_LVL_MID)
		else $error("segment at mid level");
	seg_io_a: assert property (!OPT_SEG_LCD[0] && !power_down ##1
		!power_down |-> lcd_drive_ff.seg[9] == ($past(gpio_out[0]) ?
		lsd_pkg::LSD_LVL_TOP : lsd_pkg::LSD_LVL_GND))
		else $error("io segment wrong");
	spare_seg_a: assert property (!LARGE && DUTY3 |->
		lcd_drive_ff.seg[20:19] == '0)
		else $error("spare segment driven");
	shared_pin_a: assert property (shared_common_segment_pin ==
		(!LARGE && DUTY3 ? lcd_drive_ff.com[2] : lcd_drive_ff.seg[19]))
		else $error("shared pin wrong");
	frame_rate_a: assert property (held_ff <= PER)
		else $error("commons stalled");
endmodule
bind lsd_lcd_segment_driver lsd_seg_checker #(.LARGE(LARGE),
	.DUTY3(DUTY3), .DIV_EXP(DIV_EXP), .OPT_SEG_LCD(OPT_SEG_LCD),
	.PD_KEEP_ON(PD_KEEP_ON)) u_chk (.clk(clk), .rst_n(rst_n),
	.avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.power_down(power_down), .gpio_out(gpio_out),
	.lcd_drive_ff(lcd_drive_ff),
	.shared_common_segment_pin(shared_common_segment_pin));

// file: test/lsd_panel_model.sv
`timescale 1ns/1ns
module lsd_panel_model (
	input wire logic              clk,
	input wire logic              clear,
	input lsd_pkg::lsd_drive_type drive,
	input lsd_pkg::lsd_level_type com2,
	output logic [2:0][18:0]      lit_ff
);
	// Shared pin is wired to the third common of this glass
	function automatic logic hot(input int c, input int s);
		lsd_pkg::lsd_level_type cl;
		cl = (c == 2) ? com2 : drive.com[c];
		return cl != lsd_pkg::LSD_LVL_MID && drive.seg[s] != cl;
	endfunction
	// A pixel stays marked once it saw full voltage
	always_ff @(posedge clk) begin
		for (int c = 0; c < 3; c++)
			for (int s = 0; s < 19; s++)
				lit_ff[c][s] <= !clear && (lit_ff[c][s] || hot(c, s));
	end
endmodule

// file: test/lsd_lcd_segment_driver_tb.sv
`timescale 1ns/1ns
`include "lsd_cfg.svh"
module lsd_lcd_segment_driver_tb;
	logic                   clk = 1'b0;
	logic                   rst_n = 1'b0;
	logic [11:0]            adr = 12'h000;
	logic                   rd = 1'b0;
	logic                   wr_en = 1'b0;
	logic [31:0]            wdat = 32'h0;
	logic [31:0]            rdat;
	logic                   wait_rq;
	logic                   pd = 1'b0;
	logic [9:0]             gpio = 10'h000;
	logic                   clear = 1'b0;
	logic [2:0][18:0]       lit;
	lsd_pkg::lsd_drive_type drive;
	lsd_pkg::lsd_level_type shared;
	int                     err_total = 0;
	int                     comparisons = 0;
	int                     disp_m [19];

	// Small variant at 1/3 duty with segment 9 built as I/O
	lsd_lcd_segment_driver #(.LARGE(1'b0), .DUTY3(1'b1), .DIV_EXP(3),
		.OPT_SEG_LCD(10'h3FE), .PD_KEEP_ON(1'b0)) dut (.clk(clk),
		.rst_n(rst_n), .avs_address(adr), .avs_read(rd),
		.avs_write(wr_en), .avs_writedata(wdat), .avs_readdata(rdat),
		.avs_waitrequest(wait_rq), .power_down(pd), .gpio_out(gpio),
		.lcd_drive_ff(drive), .shared_common_segment_pin(shared));
	lsd_panel_model panel (.clk(clk), .clear(clear), .drive(drive),
		.com2(shared), .lit_ff(lit));

	// System clock
	always #5 clk = ~clk;

	// One bus cycle, held until wait is seen low before an edge
	task automatic bus(input logic [11:0] a, input logic w,
		input logic [7:0] d, output logic [31:0] q);
		adr <= a;
		wr_en <= w;
		rd <= !w;
		wdat <= {24'h0, d};
		// Hold the request until a rising edge samples wait low
		do begin
			@(posedge clk);
		end while (wait_rq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr_en <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_reg(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 8'h00, q);
		cmp(q, e);
	endtask
	task automatic chk_pix(input int s, input int e);
		cmp({29'h0, lit[2][s], lit[1][s], lit[0][s]}, e);
	endtask
	// Watch the glass for over two frames, then check every pixel
	task automatic scan(input bit on);
		int e;
		clear <= 1'b1;
		@(posedge clk);
		clear <= 1'b0;
		repeat (100) @(posedge clk);
		for (int s = 0; s < 19; s++) begin
			e = on ? disp_m[s] & 7 : 0;
			// Port-built segment 9 keeps its level in power down
			if (s == 9)
				e = (on || gpio[0]) ? 7 : 0;
			chk_pix(s, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		logic [31:0] q;
		void'($urandom(32'h6844));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk_reg(`LSD_BANK_SEL_OFS, 32'h0);
		chk_reg(`LSD_PTR_OFS, 32'h0);
		chk_reg(12'h020, 32'h0);
		$display("test reset_values done");
		wr(`LSD_BANK_SEL_OFS, `LSD_BANK_DISPLAY);
		for (int k = 0; k < 19; k++) begin
			disp_m[k] = $urandom & 255;
			wr(`LSD_PTR_OFS, 8'h40 + k[7:0]);
			wr(`LSD_IND_DATA_OFS, disp_m[k][7:0]);
			chk_reg(`LSD_IND_DATA_OFS, disp_m[k]);
		end
		wr(`LSD_BANK_SEL_OFS, `LSD_BANK_GENERAL);
		wr(`LSD_PTR_OFS, 8'h45);
		wr(`LSD_IND_DATA_OFS, 8'hA5);
		chk_reg(`LSD_IND_DATA_OFS, 32'hA5);
		wr(`LSD_DIRECT_BASE + 12'h118, 8'h5A);
		wr(`LSD_PTR_OFS, 8'h46);
		chk_reg(`LSD_IND_DATA_OFS, 32'h5A);
		wr(`LSD_BANK_SEL_OFS, `LSD_BANK_DISPLAY);
		chk_reg(`LSD_IND_DATA_OFS, disp_m[6]);
		$display("test bank_switch done");
		gpio <= 10'($urandom);
		scan(1'b1);
		bus(`LSD_STATUS_OFS, 1'b0, 8'h00, q);
		cmp(q & 32'h0000_0008, 32'h0000_0008);
		$display("test panel_scan done");
		pd <= 1'b1;
		repeat (4) @(posedge clk);
		scan(1'b0);
		chk_reg(`LSD_STATUS_OFS, 32'h0);
		pd <= 1'b0;
		repeat (4) @(posedge clk);
		scan(1'b1);
		$display("test power_down done");
		tally_and_finish;
	end

	// Cut a hang short
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		tally_and_finish;
	end
endmodule
